/* File: hdl/ramdac_cfg_defs.svh */
// constants of the palette device configuration port
// assumes inclusion by the main module and the bench
`ifndef RAMDAC_CFG_DEFS_SVH
`define RAMDAC_CFG_DEFS_SVH
`define SEL_ADDR        2'b00
`define SEL_INDIRECT    2'b10
`define SEL_PALETTE     2'b01
`define SEL_MODE        2'b11
`define IDX_PIXEL_MASK  8'h04
`define IDX_CMD_ONE     8'h05
`define IDX_CMD_TWO     8'h06
`define IDX_CMD_THREE   8'h07
`define MODE_PIPE_BIT   0
`define MODE_LOAD_BIT   5
`define MODE_BUS10_BIT  1
`define MODE_RES10_BIT  2
`define MODE_NORMAL_BIT 3
`define CMD1_CAL_BIT    0
`define CMD2_TRUE_BIT   7
`define CMD2_PED_BIT    6
`define CMD2_NOSYNC_BIT 5
`define CMD3_MUX_BIT    6
`define CMD3_DIV8_BIT   0
`define RST_BYTE        8'h00
`define RST_MASK        8'hff
`define RST_WORD        10'h000
`define DIV4_HALF       3'h1
`define DIV8_HALF       3'h3
`endif

/* File: hdl/ramdac_cfg_pkg.sv */
// types of the palette device configuration port
// assumes nothing beyond the defines header
package ramdac_cfg_pkg;
  typedef enum logic [1:0] {
    comp_red   = 2'b00,
    comp_green = 2'b01,
    comp_blue  = 2'b10
  } comp_e;
  typedef enum logic [1:0] {
    seq_idle = 2'b00,
    seq_one  = 2'b01,
    seq_two  = 2'b10
  } seq_e;
endpackage

/* File: hdl/palette_ram.sv */
// palette memory: one colour component per word, registered read
// assumes a single clock and write-before-read is not needed
`timescale 1ns/1ns
module palette_ram #(
  parameter int AW = 10,
  parameter int DW = 10
) (
  input  wire logic          mclk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    rdata_o <= mem[addr_i];
  end
endmodule // palette_ram

/* File: hdl/ramdac_init_config_port.sv */
// configuration register bank of a triple-DAC palette device
// assumes a host driving select, read/write and data in step with mclk_i
`timescale 1ns/1ns
`include "ramdac_cfg_defs.svh"
//
// Contract
// RULE_01 - mode bit 0 written 1,0,1 resets rgb pipelines to mux first input
// RULE_02 - mode bit 5 written 0,1,0 synchronises load clock in and out timing
// RULE_03 - pointer 04h selects pixel mask; 05h,06h,07h select command registers
// RULE_04 - writing ffh to pixel mask passes every pixel bit unmasked
// RULE_05 - command one value 01h enables calibration at every vertical sync
// RULE_06 - command two e0h selects true colour, 0 ire, sync disabled
// RULE_07 - command three 40h/41h: 2:1 mux, clock out inverted clock /4 or /8
// RULE_08 - mode 0fh means normal operation, 10-bit bus and 10-bit dac
// RULE_09 - palette load: pointer 00h, then red, green, blue per location
// RULE_10 - reading a command register returns the value last written
// RULE_11 - select 00 pointer, 10 indirect, 01 palette, 11 mode; rw low writes
// RULE_12 - after the blue component the palette address advances by one
module ramdac_init_config_port #(
  parameter int DW = 10
) (
  input  wire logic          mclk_i,
  input  wire logic          rst_i,
  input  wire logic          strobe_i,
  input  wire logic          register_select_high_i,
  input  wire logic          register_select_low_i,
  input  wire logic          rd_wr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o,
  output logic      [7:0]    pixel_mask_o,
  output logic               cal_every_vsync_o,
  output logic               true_colour_o,
  output logic               pedestal_on_o,
  output logic               sync_disable_o,
  output logic               mux_two_to_one_o,
  output logic               bus_ten_bit_o,
  output logic               dac_ten_bit_o,
  output logic               normal_op_o,
  output logic               pipeline_reset_o,
  output logic               load_sync_o,
  output logic               programmable_clock_out_o
);
  logic [7:0]    addr_ptr;
  logic [7:0]    pixel_mask;
  logic [7:0]    command_one;
  logic [7:0]    command_two;
  logic [7:0]    command_three;
  logic [7:0]    operating_mode;
  ramdac_cfg_pkg::comp_e comp;
  ramdac_cfg_pkg::seq_e  pipe_seq;
  ramdac_cfg_pkg::seq_e  load_seq;
  logic [DW-1:0] ram_rdata;
  logic [2:0]    div_cnt;
  logic [1:0]    sel;
  logic          wr;
  logic          rd;
  logic          pal_we;
  logic [9:0]    pal_addr;
  logic [2:0]    div_half;

  function automatic logic hit(input logic [1:0] s, input logic [1:0] want);
    hit = (s == want);
  endfunction

  assign sel      = {register_select_high_i, register_select_low_i};
  assign wr       = strobe_i && !rd_wr_i; // [RULE_11]
  assign rd       = strobe_i && rd_wr_i;
  assign pal_we   = wr && hit(sel, `SEL_PALETTE);
  assign pal_addr = {addr_ptr, comp};

  palette_ram #(.AW(10), .DW(DW)) u_ram (
    .mclk_i  (mclk_i),
    .we_i    (pal_we),
    .addr_i  (pal_addr),
    .wdata_i (wdata_i),
    .rdata_o (ram_rdata)
  );

  // pointer and palette component walk
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_ptr <= `RST_BYTE;
      comp     <= ramdac_cfg_pkg::comp_red;
    end else if (wr && hit(sel, `SEL_ADDR)) begin
      addr_ptr <= wdata_i[7:0]; // [RULE_09]
      comp     <= ramdac_cfg_pkg::comp_red;
    end else if (strobe_i && hit(sel, `SEL_PALETTE)) begin
      if (comp == ramdac_cfg_pkg::comp_blue) begin
        comp     <= ramdac_cfg_pkg::comp_red; // [RULE_12]
        addr_ptr <= addr_ptr + 8'h01;
      end else begin
        comp <= ramdac_cfg_pkg::comp_e'(comp + 2'b01);
      end
    end
  end

  // indirect registers, selected by the pointer
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pixel_mask    <= `RST_MASK;
      command_one   <= `RST_BYTE;
      command_two   <= `RST_BYTE;
      command_three <= `RST_BYTE;
    end else if (wr && hit(sel, `SEL_INDIRECT)) begin
      case (addr_ptr) // [RULE_03]
        `IDX_PIXEL_MASK: pixel_mask    <= wdata_i[7:0]; // [RULE_04]
        `IDX_CMD_ONE:    command_one   <= wdata_i[7:0];
        `IDX_CMD_TWO:    command_two   <= wdata_i[7:0];
        `IDX_CMD_THREE:  command_three <= wdata_i[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      operating_mode <= `RST_BYTE;
    end else if (wr && hit(sel, `SEL_MODE)) begin
      operating_mode <= wdata_i[7:0];
    end
  end

  // read path: one cycle after the strobe, palette data also registered
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= `RST_WORD;
    end else if (rd) begin
      case (sel)
        `SEL_ADDR:     rdata_o <= DW'(addr_ptr);
        `SEL_MODE:     rdata_o <= DW'(operating_mode);
        `SEL_PALETTE:  rdata_o <= ram_rdata;
        `SEL_INDIRECT: begin
          case (addr_ptr) // [RULE_10]
            `IDX_PIXEL_MASK: rdata_o <= DW'(pixel_mask);
            `IDX_CMD_ONE:    rdata_o <= DW'(command_one);
            `IDX_CMD_TWO:    rdata_o <= DW'(command_two);
            `IDX_CMD_THREE:  rdata_o <= DW'(command_three);
            default:         rdata_o <= `RST_WORD;
          endcase
        end
        default: rdata_o <= `RST_WORD;
      endcase
    end
  end

  // bit-pattern trackers for mode writes; a wrong third value restarts them, a repeated first value holds them
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pipe_seq         <= ramdac_cfg_pkg::seq_idle;
      pipeline_reset_o <= 1'b0;
    end else begin
      pipeline_reset_o <= 1'b0;
      if (wr && hit(sel, `SEL_MODE)) begin
        case (pipe_seq) // [RULE_01]
          ramdac_cfg_pkg::seq_idle:
            pipe_seq <= wdata_i[`MODE_PIPE_BIT] ? ramdac_cfg_pkg::seq_one
                                                : ramdac_cfg_pkg::seq_idle;
          ramdac_cfg_pkg::seq_one:
            pipe_seq <= wdata_i[`MODE_PIPE_BIT] ? ramdac_cfg_pkg::seq_one
                                                : ramdac_cfg_pkg::seq_two;
          ramdac_cfg_pkg::seq_two: begin
            if (wdata_i[`MODE_PIPE_BIT]) begin
              pipeline_reset_o <= 1'b1;
              pipe_seq         <= ramdac_cfg_pkg::seq_one;
            end else begin
              pipe_seq <= ramdac_cfg_pkg::seq_idle;
            end
          end
          default: pipe_seq <= ramdac_cfg_pkg::seq_idle;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      load_seq    <= ramdac_cfg_pkg::seq_idle;
      load_sync_o <= 1'b0;
    end else begin
      load_sync_o <= 1'b0;
      if (wr && hit(sel, `SEL_MODE)) begin
        case (load_seq) // [RULE_02]
          ramdac_cfg_pkg::seq_idle:
            load_seq <= wdata_i[`MODE_LOAD_BIT] ? ramdac_cfg_pkg::seq_idle
                                                : ramdac_cfg_pkg::seq_one;
          ramdac_cfg_pkg::seq_one:
            load_seq <= wdata_i[`MODE_LOAD_BIT] ? ramdac_cfg_pkg::seq_two
                                                : ramdac_cfg_pkg::seq_one;
          ramdac_cfg_pkg::seq_two: begin
            if (!wdata_i[`MODE_LOAD_BIT]) begin
              load_sync_o <= 1'b1;
              load_seq    <= ramdac_cfg_pkg::seq_one;
            end else begin
              load_seq <= ramdac_cfg_pkg::seq_idle;
            end
          end
          default: load_seq <= ramdac_cfg_pkg::seq_idle;
        endcase
      end
    end
  end

  // decoded configuration levels, registered so every output is a flop
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pixel_mask_o      <= `RST_MASK;
      cal_every_vsync_o <= 1'b0;
      true_colour_o     <= 1'b0;
      pedestal_on_o     <= 1'b0;
      sync_disable_o    <= 1'b0;
      mux_two_to_one_o  <= 1'b0;
      bus_ten_bit_o     <= 1'b0;
      dac_ten_bit_o     <= 1'b0;
      normal_op_o       <= 1'b0;
    end else begin
      pixel_mask_o      <= pixel_mask; // [RULE_04]
      cal_every_vsync_o <= command_one[`CMD1_CAL_BIT]; // [RULE_05]
      true_colour_o     <= command_two[`CMD2_TRUE_BIT]; // [RULE_06]
      pedestal_on_o     <= command_two[`CMD2_PED_BIT] ^ command_two[`CMD2_TRUE_BIT];
      sync_disable_o    <= command_two[`CMD2_NOSYNC_BIT];
      mux_two_to_one_o  <= command_three[`CMD3_MUX_BIT]; // [RULE_07]
      bus_ten_bit_o     <= operating_mode[`MODE_BUS10_BIT]; // [RULE_08]
      dac_ten_bit_o     <= operating_mode[`MODE_RES10_BIT];
      normal_op_o       <= operating_mode[`MODE_NORMAL_BIT];
    end
  end

  // clock out: inverted at reset, half period 2 or 4 cycles gives /4 or /8
  assign div_half = command_three[`CMD3_DIV8_BIT] ? `DIV8_HALF : `DIV4_HALF; // [RULE_07]

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt                  <= 3'h0;
      programmable_clock_out_o <= 1'b1;
    end else if (div_cnt >= div_half) begin
      div_cnt                  <= 3'h0;
      programmable_clock_out_o <= !programmable_clock_out_o;
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  sequence s_pipe_101;
    (wr && sel == `SEL_MODE && wdata_i[`MODE_PIPE_BIT] && pipe_seq == ramdac_cfg_pkg::seq_two);
  endsequence

  a_pipe_reset_pulse: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE_01]
    s_pipe_101 |=> pipeline_reset_o) else $error("pipeline reset missed");
  a_load_sync_pulse: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE_02]
    load_sync_o |-> $past(wr) && !$past(wdata_i[`MODE_LOAD_BIT])) else $error("load sync bad");
  a_mask_write_path: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE_04]
    (wr && sel == `SEL_INDIRECT && addr_ptr == `IDX_PIXEL_MASK) |=> ##1
    pixel_mask_o == $past(wdata_i[7:0], 2)) else $error("pixel mask not taken");
  a_cmd_readback: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE_10]
    (rd && sel == `SEL_INDIRECT && addr_ptr == `IDX_CMD_TWO) |=>
    rdata_o == DW'(command_two)) else $error("command readback wrong");
  a_ptr_load: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE_09]
    (wr && sel == `SEL_ADDR) |=>
    addr_ptr == $past(wdata_i[7:0]) && comp == ramdac_cfg_pkg::comp_red)
    else $error("pointer load wrong");
  a_ptr_advance: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE_12]
    (strobe_i && sel == `SEL_PALETTE && comp == ramdac_cfg_pkg::comp_blue) |=>
    addr_ptr == $past(addr_ptr) + 8'h01) else $error("palette address not advanced");
  a_mode_decode: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE_08]
    (wr && sel == `SEL_MODE && wdata_i[7:0] == 8'h0f) |=> ##1
    (bus_ten_bit_o && dac_ten_bit_o && normal_op_o)) else $error("mode decode wrong");
  a_cal_decode: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE_05]
    (wr && sel == `SEL_INDIRECT && addr_ptr == `IDX_CMD_ONE && wdata_i[7:0] == 8'h01) |=> ##1
    cal_every_vsync_o) else $error("calibration enable missed");
  a_clk_div_bound: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE_07]
    div_cnt <= `DIV8_HALF) else $error("divider counter out of range");
endmodule // ramdac_init_config_port

/* File: tb/host_mpu_model.sv */
// host processor model on the parallel configuration port
// assumes the bench calls access() and a single clock mclk_i
`timescale 1ns/1ns
module host_mpu_model (
  input  wire logic       mclk_i,
  output logic            strobe_o,
  output logic            sel_high_o,
  output logic            sel_low_o,
  output logic            rd_wr_o,
  output logic [9:0]      wdata_o,
  input  wire logic [9:0] rdata_i
);
  initial begin
    {strobe_o, sel_high_o, sel_low_o, rd_wr_o, wdata_o} = '0;
  end

  // one access: driven on a falling edge, taken on the next rising edge
  task automatic access(input logic [1:0] sel, input logic rw, input logic [9:0] data,
                        output logic [9:0] rd);
    @(negedge mclk_i);
    strobe_o = 1'b1;
    {sel_high_o, sel_low_o} = sel;
    rd_wr_o = rw;
    wdata_o = data;
    @(posedge mclk_i);
    @(negedge mclk_i);
    strobe_o = 1'b0;
    // released bus shows the inverse, so a stale capture cannot pass
    wdata_o = ~data;
    @(posedge mclk_i);
    @(negedge mclk_i);
    rd = rdata_i;
  endtask
endmodule // host_mpu_model

/* File: tb/ramdac_init_config_port_bench.sv */
// self-checking bench of the palette device configuration port
// assumes the host model in host_mpu_model.sv and a 25 MHz clock
`timescale 1ns/1ns
`include "ramdac_cfg_defs.svh"
`define CHECK(what, exp, got) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("unexpected %s expected %h seen %h", what, exp, got); \
  end \
end
module ramdac_init_config_port_bench;
  logic        mclk_i = 1'b0;
  logic        rst_i  = 1'b1;
  logic        strobe, sel_high, sel_low, rd_wr;
  logic [9:0]  wdata, rdata, rd, v;
  logic [7:0]  pmask;
  logic        cal, tc, ped, sdis, mux, bus10, dac10, norm, prst, lsync, pclk;
  logic [31:0] seed = 32'd74467;
  logic [9:0]  pal [6];
  logic [9:0]  mode_seq [5] = '{10'h00f, 10'h00e, 10'h00f, 10'h02f, 10'h00f};
  int          fails = 0;
  int          check_count = 0;
  int          pipe_pulses = 0;
  int          load_pulses = 0;
  int          n;

  always #20 mclk_i = ~mclk_i;

  host_mpu_model u_host_mpu_model (.mclk_i(mclk_i), .strobe_o(strobe), .sel_high_o(sel_high),
    .sel_low_o(sel_low), .rd_wr_o(rd_wr), .wdata_o(wdata), .rdata_i(rdata));

  ramdac_init_config_port u_ramdac_init_config_port (.mclk_i(mclk_i), .rst_i(rst_i),
    .strobe_i(strobe), .register_select_high_i(sel_high), .register_select_low_i(sel_low),
    .rd_wr_i(rd_wr), .wdata_i(wdata), .rdata_o(rdata), .pixel_mask_o(pmask),
    .cal_every_vsync_o(cal), .true_colour_o(tc), .pedestal_on_o(ped), .sync_disable_o(sdis),
    .mux_two_to_one_o(mux), .bus_ten_bit_o(bus10), .dac_ten_bit_o(dac10), .normal_op_o(norm),
    .pipeline_reset_o(prst), .load_sync_o(lsync), .programmable_clock_out_o(pclk));

  always @(posedge mclk_i) begin
    if (prst === 1'b1) pipe_pulses++;
    if (lsync === 1'b1) load_pulses++;
  end

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic wr(input logic [1:0] sel, input logic [9:0] d);
    u_host_mpu_model.access(sel, 1'b0, d, rd);
  endtask

  task automatic rdb(input logic [1:0] sel, output logic [9:0] q);
    u_host_mpu_model.access(sel, 1'b1, 10'h000, q);
  endtask

  // cycles from one rising edge of the divided clock to the next
  task automatic clk_period(output int p);
    do @(negedge mclk_i); while (pclk !== 1'b0);
    do @(negedge mclk_i); while (pclk !== 1'b1);
    p = 0;
    do begin @(negedge mclk_i); p++; end while (pclk !== 1'b0);
    do begin @(negedge mclk_i); p++; end while (pclk !== 1'b1);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // some 48 accesses of three cycles each; ample margin for the clock measurements
  initial begin
    repeat (20000) @(posedge mclk_i);
    fails++;
    $display("watchdog expired");
    give_verdict();
  end

  initial begin
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 1'b0;
    `CHECK("mask at reset", 8'hff, pmask)
    `CHECK("clock out at reset", 1'b1, pclk)
    foreach (mode_seq[i]) wr(`SEL_MODE, mode_seq[i]);
    repeat (2) @(negedge mclk_i);
    `CHECK("pipeline resets", 1, pipe_pulses)
    `CHECK("load syncs", 1, load_pulses)
    `CHECK("normal mode", 3'b111, {bus10, dac10, norm})
    rdb(`SEL_MODE, v);
    `CHECK("mode read back", 10'h00f, v)
    $display("end of mode test");
    wr(`SEL_ADDR, 10'h004);
    rdb(`SEL_ADDR, v);
    `CHECK("pointer read back", 10'h004, v)
    // mask resets to ff, so clear it first or the ff check below cannot fail
    wr(`SEL_INDIRECT, 10'h000);
    `CHECK("pixel mask cleared", 8'h00, pmask)
    wr(`SEL_INDIRECT, 10'h0ff);
    `CHECK("pixel mask", 8'hff, pmask)
    wr(`SEL_ADDR, 10'h005);
    wr(`SEL_INDIRECT, 10'h001);
    `CHECK("calibration", 1'b1, cal)
    wr(`SEL_ADDR, 10'h006);
    wr(`SEL_INDIRECT, 10'h0e0);
    `CHECK("colour pedestal sync", 3'b101, {tc, ped, sdis})
    wr(`SEL_ADDR, 10'h007);
    wr(`SEL_INDIRECT, 10'h040);
    `CHECK("mux two to one", 1'b1, mux)
    clk_period(n);
    `CHECK("clock out period", 4, n)
    wr(`SEL_INDIRECT, 10'h041);
    clk_period(n);
    `CHECK("clock out period", 8, n)
    $display("end of command test");
    // index 8 is unmapped: the write is dropped and reads give zero
    for (int i = 4; i <= 8; i++) begin
      seed = next_rand(seed);
      wr(`SEL_ADDR, 10'(i));
      wr(`SEL_INDIRECT, {2'b00, seed[7:0]});
      rdb(`SEL_INDIRECT, v);
      `CHECK("read back", (i == 8) ? 8'h00 : seed[7:0], v[7:0])
    end
    $display("end of read back test");
    wr(`SEL_ADDR, 10'h000);
    foreach (pal[i]) begin
      seed = next_rand(seed);
      pal[i] = (i == 5) ? 10'h3ff : seed[9:0];
      wr(`SEL_PALETTE, pal[i]);
    end
    wr(`SEL_ADDR, 10'h000);
    foreach (pal[i]) begin
      rdb(`SEL_PALETTE, v);
      `CHECK("palette word", pal[i], v)
    end
    wr(`SEL_ADDR, 10'h001);
    rdb(`SEL_PALETTE, v);
    `CHECK("second location red", pal[3], v)
    $display("end of palette test");
    give_verdict();
  end
endmodule // ramdac_init_config_port_bench
